// ==== rtl/spic_consts.svh ====
// Offsets, bit positions, reset values and divider counts of the serial port control block
`ifndef SPIC_CONSTS_SVH
`define SPIC_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPIC_OFS_CTRL 2'h0
`define SPIC_OFS_STAT 2'h1
`define SPIC_OFS_DATA 2'h2

// ----------------------------------------
// Control register bits
// ----------------------------------------
`define SPIC_CR_RXIE 7
`define SPIC_CR_MSTR 5
`define SPIC_CR_CPOL 4
`define SPIC_CR_CLOCK_PHASE 3
`define SPIC_CR_WOM 2
`define SPIC_CR_SPE 1
`define SPIC_CR_TXIE 0
`define SPIC_CR_RESET 8'h28

// ----------------------------------------
// Status and control register bits
// ----------------------------------------
`define SPIC_SR_RXF 7
`define SPIC_SR_ERROR_IRQ_ENABLE 6
`define SPIC_SR_OVR 5
`define SPIC_SR_MODE_FAULT_FLAG 4
`define SPIC_SR_TXE 3
`define SPIC_SR_MODE_FAULT_DETECT_ENABLE 2
`define SPIC_SR_SPR_HI 1
`define SPIC_SR_SPR_LO 0

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define SPIC_HALF_DIV2 6'h00
`define SPIC_HALF_DIV8 6'h03
`define SPIC_HALF_DIV32 6'h0f
`define SPIC_HALF_DIV128 6'h3f
`define SPIC_LAST_EDGE 4'hf
`define SPIC_FIRST_EDGE 4'h1

`endif

// ==== rtl/spic_pkg.sv ====
// Types shared by the serial port control block
package spic_pkg;

  typedef enum logic [0:0] {
    SPIC_IDLE,
    SPIC_RUN
  } spic_state_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
  } spic_pins_t;

endpackage : spic_pkg

// ==== rtl/spic_top.sv ====
// Serial port control block: registers, flags, requests, shifter and pin ownership
//
// What this block does
// - Transmit request needs empty, enable, port on
// - Receive request on full and enable
// - Error enable passes overrun or fault
// - Fault flag never sets without detection
// - Status read then data read clears full
// - Data write clears transmit empty
// - Byte moves set full and empty flags
// - Port off: empty set, transfer aborted, pins freed
// - Port off keeps control bits and full, overrun and fault flags
// - Master fault clears port enable
// - Wait mode: runs, registers closed, wakes
// - Stop mode halts, keeps register contents
// - Break with clear enable lets flags clear
// - Break without clear enable protects flags
// - Protected break data write does nothing
// - Slave drives MISO only while selected
// - Enabled port owns data and clock pins
// - Clock out as master; eight clocks per byte
// - Deselected slave ignores clock edges
// - Select pin freed when off or unchecked master
// - Fault clear: status read, control write, no fault
// - Status read then data read clears overrun
`timescale 1ns/1ps
`include "spic_consts.svh"

module spic_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // System states
  input wire logic wait_mode_in,
  input wire logic stop_mode_in,
  input wire logic break_in,
  input wire logic break_flag_clear_enable_in,
  // Serial pins
  input wire spic_pkg::spic_pins_t pins_in,
  input wire logic ss_b_in,
  output spic_pkg::spic_pins_t pins_out,
  output spic_pkg::spic_pins_t pins_oe_b_out,
  output logic spi_owns_pins_out,
  output logic ss_gpio_out,
  // Requests
  output logic tx_irq_out,
  output logic rx_err_irq_out,
  output logic wake_out
);
  import spic_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic error_irq_enable_q, mode_fault_detect_enable_q;
  logic [1:0] spr_q;
  logic rxf_q, ovr_q, mode_fault_flag_q, txe_q;
  logic arm_rxf_q, arm_ovr_q, arm_mode_fault_flag_q;
  logic [7:0] tx_q, rx_q, sh_q;
  spic_pins_t pin_s1_q, pin_s2_q;
  logic ss_s1_q, ss_s2_q, ss_s3_q, sclk_s3_q;
  spic_state_t state_q;
  logic [3:0] cnt_q;
  logic [5:0] div_q;
  logic sck_q, out_q, done_q;
  logic [7:0] rdata_q;
  spic_pins_t pins_q, oe_b_q;
  logic own_q, ss_gpio_q, tx_irq_q, rx_irq_q, wake_q;
  logic spi_enable, mstr, clock_phase, cpol, wom, slave_sel, brk_protect, acc_ok;
  logic st_rd, st_wr, dt_rd, dt_wr, cr_wr;
  logic m_tick, s_edge, edge_ev, lead, sample, shift, m_start, s_start, start, take_tx, in_bit;
  logic mode_fault_flag_cond, master_fault, clr_rxf, clr_ovr, clr_mode_fault_flag, rx_avail;
  logic [7:0] src;

  function automatic logic [5:0] half_reload(input logic [1:0] sel);
    case (sel)
      2'h0: half_reload = `SPIC_HALF_DIV2;
      2'h1: half_reload = `SPIC_HALF_DIV8;
      2'h2: half_reload = `SPIC_HALF_DIV32;
      default: half_reload = `SPIC_HALF_DIV128;
    endcase
  endfunction : half_reload

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      ss_s1_q <= 1'b1;
      ss_s2_q <= 1'b1;
      ss_s3_q <= 1'b1;
      sclk_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= pins_in;
      pin_s2_q <= pin_s1_q;
      ss_s1_q <= ss_b_in;
      ss_s2_q <= ss_s1_q;
      ss_s3_q <= ss_s2_q;
      sclk_s3_q <= pin_s2_q.sclk;
    end
  end

  // ----------------------------------------
  // Decode and engine events
  // ----------------------------------------
  always_comb begin
    spi_enable = ctrl_q[`SPIC_CR_SPE];
    mstr = ctrl_q[`SPIC_CR_MSTR];
    clock_phase = ctrl_q[`SPIC_CR_CLOCK_PHASE];
    cpol = ctrl_q[`SPIC_CR_CPOL];
    wom = ctrl_q[`SPIC_CR_WOM];
    acc_ok = ~wait_mode_in;
    brk_protect = break_in & ~break_flag_clear_enable_in;
    st_rd = 1'b0;
    st_wr = 1'b0;
    dt_rd = 1'b0;
    dt_wr = 1'b0;
    cr_wr = 1'b0;
    if (addr_in == `SPIC_OFS_STAT) begin
      st_rd = rd_in & acc_ok;
      st_wr = wr_in & acc_ok;
    end else if (addr_in == `SPIC_OFS_DATA) begin
      dt_rd = rd_in & acc_ok;
      dt_wr = wr_in & acc_ok;
    end else if (addr_in == `SPIC_OFS_CTRL) begin
      cr_wr = wr_in & acc_ok;
    end
    slave_sel = spi_enable & ~mstr & ~ss_s2_q;
    m_tick = spi_enable & mstr & (state_q == SPIC_RUN) & (div_q == 6'h00) & ~stop_mode_in;
    s_edge = slave_sel & (pin_s2_q.sclk != sclk_s3_q) & ~stop_mode_in;
    edge_ev = mstr ? m_tick : (s_edge & (state_q == SPIC_RUN));
    lead = ~cnt_q[0];
    sample = edge_ev & (lead != clock_phase);
    shift = edge_ev & (lead == clock_phase);
    in_bit = mstr ? pin_s2_q.miso : pin_s2_q.mosi;
    m_start = spi_enable & mstr & (state_q == SPIC_IDLE) & ~txe_q & ~stop_mode_in;
    s_start = spi_enable & ~mstr & (state_q == SPIC_IDLE) & ~stop_mode_in &
              (clock_phase ? s_edge : (slave_sel & ss_s3_q));
    start = m_start | s_start;
    take_tx = start & ~txe_q;
    src = txe_q ? sh_q : tx_q;
    mode_fault_flag_cond = mode_fault_detect_enable_q & spi_enable &
                (mstr ? ~ss_s2_q : (ss_s2_q & ~ss_s3_q & (state_q == SPIC_RUN)));
    master_fault = mode_fault_flag_cond & mstr;
    clr_rxf = dt_rd & arm_rxf_q & ~brk_protect;
    clr_ovr = dt_rd & arm_ovr_q & ~brk_protect;
    clr_mode_fault_flag = cr_wr & arm_mode_fault_flag_q & ~brk_protect & ~mode_fault_flag_cond;
    rx_avail = ~rxf_q | clr_rxf;
  end

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= `SPIC_CR_RESET;
      error_irq_enable_q <= 1'b0;
      mode_fault_detect_enable_q <= 1'b0;
      spr_q <= 2'h0;
    end else begin
      if (cr_wr) begin
        ctrl_q <= wdata_in;
      end
      if (master_fault) begin
        ctrl_q[`SPIC_CR_SPE] <= 1'b0;
      end
      if (st_wr) begin
        error_irq_enable_q <= wdata_in[`SPIC_SR_ERROR_IRQ_ENABLE];
        mode_fault_detect_enable_q <= wdata_in[`SPIC_SR_MODE_FAULT_DETECT_ENABLE];
        spr_q <= wdata_in[`SPIC_SR_SPR_HI:`SPIC_SR_SPR_LO];
      end
    end
  end

  // ----------------------------------------
  // Status flags and clearing sequences
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rxf_q <= 1'b0;
      ovr_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      txe_q <= 1'b1;
      arm_rxf_q <= 1'b0;
      arm_ovr_q <= 1'b0;
      arm_mode_fault_flag_q <= 1'b0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
    end else begin
      if (st_rd & ~brk_protect) begin
        arm_rxf_q <= rxf_q;
        arm_ovr_q <= ovr_q;
        arm_mode_fault_flag_q <= mode_fault_flag_q;
      end
      if (clr_rxf) begin
        rxf_q <= 1'b0;
        arm_rxf_q <= 1'b0;
      end
      if (clr_ovr) begin
        ovr_q <= 1'b0;
        arm_ovr_q <= 1'b0;
      end
      if (clr_mode_fault_flag) begin
        mode_fault_flag_q <= 1'b0;
      end
      if (clr_mode_fault_flag | mode_fault_flag_cond) begin
        arm_mode_fault_flag_q <= 1'b0;
      end
      if (dt_wr & ~brk_protect) begin
        tx_q <= wdata_in;
        txe_q <= 1'b0;
      end
      if (done_q & ~(ovr_q & ~clr_ovr)) begin
        if (rx_avail) begin
          rx_q <= sh_q;
          rxf_q <= 1'b1;
        end else begin
          ovr_q <= 1'b1;
        end
      end
      if (mode_fault_flag_cond) begin
        mode_fault_flag_q <= 1'b1;
      end
      if (take_tx | ~spi_enable) begin
        txe_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= SPIC_IDLE;
      cnt_q <= 4'h0;
      div_q <= 6'h00;
      sh_q <= 8'h00;
      out_q <= 1'b0;
      sck_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!spi_enable) begin
        state_q <= SPIC_IDLE;
        cnt_q <= 4'h0;
        sh_q <= 8'h00;
        sck_q <= cpol;
      end else if (~mstr & ss_s2_q) begin
        state_q <= SPIC_IDLE;
        cnt_q <= 4'h0;
      end else if (start) begin
        state_q <= SPIC_RUN;
        sh_q <= src;
        if (!clock_phase || !mstr) begin
          out_q <= src[7];
        end
        cnt_q <= (clock_phase & ~mstr) ? `SPIC_FIRST_EDGE : 4'h0;
        div_q <= half_reload(spr_q);
        sck_q <= cpol;
      end else if (state_q == SPIC_RUN && !stop_mode_in) begin
        if (mstr) begin
          div_q <= (div_q == 6'h00) ? half_reload(spr_q) : div_q - 6'h01;
          if (m_tick) begin
            sck_q <= ~sck_q;
          end
        end
        if (edge_ev) begin
          cnt_q <= cnt_q + 4'h1;
          if (sample) begin
            sh_q <= {sh_q[6:0], in_bit};
          end
          if (shift) begin
            out_q <= sh_q[7];
          end
          if (cnt_q == `SPIC_LAST_EDGE) begin
            state_q <= SPIC_IDLE;
            cnt_q <= 4'h0;
            done_q <= 1'b1;
          end
        end
      end else if (state_q == SPIC_IDLE) begin
        sck_q <= cpol;
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= 8'h00;
      if (rd_in & acc_ok) begin
        if (addr_in == `SPIC_OFS_CTRL) begin
          rdata_q <= ctrl_q;
        end else if (addr_in == `SPIC_OFS_STAT) begin
          rdata_q <= {rxf_q, error_irq_enable_q, ovr_q, mode_fault_flag_q, txe_q, mode_fault_detect_enable_q, spr_q};
        end else if (addr_in == `SPIC_OFS_DATA) begin
          rdata_q <= rx_q;
        end
      end
    end
  end

  // ----------------------------------------
  // Pin ownership and drivers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pins_q <= '0;
      oe_b_q <= '1;
      own_q <= 1'b0;
      ss_gpio_q <= 1'b1;
    end else begin
      own_q <= spi_enable;
      ss_gpio_q <= ~spi_enable | (mstr & ~mode_fault_detect_enable_q);
      pins_q.sclk <= sck_q;
      pins_q.mosi <= out_q;
      pins_q.miso <= out_q;
      oe_b_q <= '1;
      if (spi_enable && mstr) begin
        oe_b_q.sclk <= wom & sck_q;
        oe_b_q.mosi <= wom & out_q;
      end else if (spi_enable && !ss_s2_q) begin
        oe_b_q.miso <= wom & out_q;
      end
    end
  end

  // ----------------------------------------
  // Requests
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      tx_irq_q <= txe_q & ctrl_q[`SPIC_CR_TXIE] & spi_enable;
      rx_irq_q <= (rxf_q & ctrl_q[`SPIC_CR_RXIE]) | (error_irq_enable_q & (ovr_q | mode_fault_flag_q));
      wake_q <= wait_mode_in & (tx_irq_q | rx_irq_q);
    end
  end

  assign rdata_out = rdata_q;
  assign pins_out = pins_q;
  assign pins_oe_b_out = oe_b_q;
  assign spi_owns_pins_out = own_q;
  assign ss_gpio_out = ss_gpio_q;
  assign tx_irq_out = tx_irq_q;
  assign rx_err_irq_out = rx_irq_q;
  assign wake_out = wake_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_tx_irq_gate: assert property (tx_irq_out |-> $past(txe_q & ctrl_q[`SPIC_CR_TXIE] & spi_enable))
    else $error("transmit request without its conditions");
  a_rx_irq_level: assert property (rxf_q & ctrl_q[`SPIC_CR_RXIE] |=> rx_err_irq_out)
    else $error("receive request missing");
  a_err_irq_path: assert property (error_irq_enable_q & ovr_q |=> rx_err_irq_out)
    else $error("overrun request missing");
  a_mode_fault_flag_blocked: assert property (~mode_fault_detect_enable_q & ~mode_fault_flag_q |=> ~mode_fault_flag_q)
    else $error("fault flag set with detection off");
  a_rxf_clear: assert property (clr_rxf & ~done_q |=> ~rxf_q)
    else $error("full flag not cleared");
  a_txe_write: assert property (dt_wr & ~brk_protect & ~take_tx & spi_enable |=> ~txe_q)
    else $error("empty flag not cleared by write");
  a_disable_reset: assert property (~spi_enable |=> txe_q & (state_q == SPIC_IDLE) & (sh_q == 8'h00))
    else $error("partial reset incomplete");
  a_fault_disable: assert property (master_fault |=> ~spi_enable ##1 ~spi_owns_pins_out)
    else $error("master fault left port enabled");
  a_brk_write: assert property (dt_wr & brk_protect & txe_q |=> txe_q && tx_q == $past(tx_q))
    else $error("protected write took effect");
  a_miso_hiz: assert property (spi_enable & ~mstr & ss_s2_q |=> pins_oe_b_out.miso)
    else $error("deselected slave drove data");
  a_ss_ignore: assert property (spi_enable & ~mstr & ss_s2_q |=> state_q == SPIC_IDLE && cnt_q == 4'h0)
    else $error("deselected slave kept counting");

  c_master_byte: cover property (mstr & done_q);
  c_slave_byte: cover property (~mstr & done_q);
  c_overrun: cover property (~ovr_q ##1 ovr_q);
  c_mode_fault: cover property (~mode_fault_flag_q ##1 mode_fault_flag_q);

endmodule : spic_top

// ==== verif/spic_far_end.sv ====
// Remote serial slave answering the port's master transfers
`timescale 1ns/1ps

module spic_far_end (
  // Clock and frame
  input wire logic clk_in,
  input wire logic sel_in,
  // Line
  output logic miso_out
);
  logic lvl_q = 1'b0;

  // Ones inside a frame; a changing level once released
  always @(posedge clk_in) begin
    lvl_q <= sel_in ? 1'b1 : ~lvl_q;
  end
  assign miso_out = lvl_q;
endmodule : spic_far_end

// ==== verif/spic_top_test.sv ====
// Self-checking bench of the serial port control block
`timescale 1ns/1ps

module spic_top_test;
  import spic_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, d;
  logic wt = 1'b0;
  logic brk = 1'b0;
  logic stop = 1'b0;
  logic break_flag_clear_enable = 1'b0;
  logic ss_b = 1'b1;
  logic sck = 1'b0;
  logic sel = 1'b0;
  logic far_miso, own, ss_gpio, tx_irq, rx_irq, wake, prev_sck;
  spic_pins_t pins_i, pins_o, oe_b;
  logic [7:0] n_edges = 8'h00;
  logic [7:0] mosi_sr = 8'h00;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  // Wire levels from every driver
  assign pins_i = {oe_b.sclk ? sck : pins_o.sclk, oe_b.mosi ? 1'b1 : pins_o.mosi,
                   oe_b.miso ? far_miso : pins_o.miso};

  spic_top DUT (
    .clk_in(clk), .rst_b_in(rst_b), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .wait_mode_in(wt), .stop_mode_in(stop), .break_in(brk),
    .break_flag_clear_enable_in(break_flag_clear_enable), .pins_in(pins_i), .ss_b_in(ss_b), .pins_out(pins_o),
    .pins_oe_b_out(oe_b), .spi_owns_pins_out(own), .ss_gpio_out(ss_gpio),
    .tx_irq_out(tx_irq), .rx_err_irq_out(rx_irq), .wake_out(wake)
  );

  spic_far_end far (.clk_in(clk), .sel_in(sel), .miso_out(far_miso));

  // Serial clock edge count
  always @(posedge clk) begin
    prev_sck <= pins_o.sclk;
    if (prev_sck !== pins_o.sclk && !oe_b.sclk) n_edges <= n_edges + 8'h01;
    if (prev_sck === 1'b1 && pins_o.sclk === 1'b0 && !oe_b.sclk) mosi_sr <= {mosi_sr[6:0], pins_o.mosi};
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    rreg(a, d);
    chk(d, exp);
  endtask : rchk

  task automatic xfer(input logic load);
    int k;
    logic [7:0] base;
    base = n_edges;
    sel = 1'b1;
    if (load) begin
      wreg(2'h2, 8'h3c);
    end else begin
      wait_clk(3);
      stop <= 1'b0;
    end
    for (k = 0; k < 200 && n_edges - base != 8'h10; k++) wait_clk(1);
    wait_clk(8);
    sel = 1'b0;
    chk(n_edges - base, 8'h10);
    chk(mosi_sr, 8'h3c);
  endtask : xfer

  task automatic t_reset;
    rchk(2'h0, 8'h28);
    rchk(2'h1, 8'h08);
    chk({tx_irq, rx_irq, own, ss_gpio}, 8'h01);
    $display("reset test done");
  endtask : t_reset

  task automatic t_txirq;
    wreg(2'h0, 8'h29);
    wait_clk(3);
    chk(tx_irq, 8'h00);
    wreg(2'h0, 8'h2b);
    wait_clk(3);
    chk({tx_irq, own, ss_gpio, oe_b.sclk}, 8'h0e);
    $display("transmit request test done");
  endtask : t_txirq

  task automatic t_master;
    logic [7:0] e0;
    e0 = n_edges;
    stop <= 1'b1;
    wreg(2'h2, 8'h3c);
    wait_clk(8);
    rchk(2'h1, 8'h00);
    chk(n_edges - e0, 8'h00);
    xfer(1'b0);
    rchk(2'h1, 8'h88);
    wreg(2'h0, 8'hab);
    wait_clk(2);
    chk(rx_irq, 8'h01);
    rreg(2'h1, d);
    rchk(2'h2, 8'hff);
    rchk(2'h1, 8'h08);
    chk(rx_irq, 8'h00);
    wreg(2'h0, 8'h2b);
    $display("master transfer test done");
  endtask : t_master

  task automatic t_overrun;
    xfer(1'b1);
    xfer(1'b1);
    rchk(2'h1, 8'ha8);
    wreg(2'h1, 8'h40);
    wait_clk(2);
    chk(rx_irq, 8'h01);
    rreg(2'h1, d);
    rreg(2'h2, d);
    rchk(2'h1, 8'h48);
    chk(rx_irq, 8'h00);
    $display("overrun test done");
  endtask : t_overrun

  task automatic t_fault;
    ss_b = 1'b0;
    wait_clk(6);
    rchk(2'h1, 8'h48);
    ss_b = 1'b1;
    wreg(2'h1, 8'h44);
    wait_clk(3);
    chk(ss_gpio, 8'h00);
    ss_b = 1'b0;
    wait_clk(6);
    rchk(2'h0, 8'h29);
    rchk(2'h1, 8'h5c);
    chk({rx_irq, own}, 8'h02);
    ss_b = 1'b1;
    wait_clk(4);
    rreg(2'h1, d);
    wreg(2'h0, 8'h29);
    rchk(2'h1, 8'h4c);
    wreg(2'h1, 8'h40);
    wreg(2'h0, 8'h2b);
    $display("mode fault test done");
  endtask : t_fault

  task automatic t_break;
    logic [7:0] e0;
    e0 = n_edges;
    brk <= 1'b1;
    wreg(2'h2, 8'h55);
    wait_clk(40);
    chk(n_edges - e0, 8'h00);
    rchk(2'h1, 8'h48);
    brk <= 1'b0;
    xfer(1'b1);
    rreg(2'h1, d);
    brk <= 1'b1;
    rreg(2'h2, d);
    rchk(2'h1, 8'hc8);
    brk <= 1'b0;
    rchk(2'h2, 8'hff);
    rchk(2'h1, 8'h48);
    xfer(1'b1);
    brk <= 1'b1;
    break_flag_clear_enable <= 1'b1;
    rreg(2'h1, d);
    rreg(2'h2, d);
    brk <= 1'b0;
    break_flag_clear_enable <= 1'b0;
    rchk(2'h1, 8'h48);
    $display("break test done");
  endtask : t_break

  task automatic t_wait;
    wt <= 1'b1;
    wait_clk(3);
    chk(wake, 8'h01);
    rchk(2'h0, 8'h00);
    wreg(2'h0, 8'h00);
    wt <= 1'b0;
    rchk(2'h0, 8'h2b);
    $display("wait test done");
  endtask : t_wait

  task automatic t_slave;
    wreg(2'h1, 8'h00);
    wreg(2'h0, 8'h0b);
    repeat (16) #100 sck = ~sck;
    wait_clk(4);
    chk({oe_b.miso, oe_b.sclk, ss_gpio}, 8'h06);
    rchk(2'h1, 8'h08);
    ss_b = 1'b0;
    wait_clk(4);
    chk(oe_b.miso, 8'h00);
    repeat (16) #100 sck = ~sck;
    #200 ss_b = 1'b1;
    wait_clk(4);
    rchk(2'h1, 8'h88);
    rreg(2'h2, d);
    wreg(2'h0, 8'h03);
    wait_clk(2);
    ss_b = 1'b0;
    wait_clk(4);
    repeat (16) #100 sck = ~sck;
    #200 ss_b = 1'b1;
    wait_clk(4);
    rchk(2'h1, 8'h88);
    rchk(2'h2, 8'hff);
    $display("slave test done");
  endtask : t_slave

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_txirq();
    t_master();
    t_overrun();
    t_fault();
    t_break();
    t_wait();
    t_slave();
    complete_run();
  end
endmodule : spic_top_test
